// ===== verilog/nsic_ctrl.sv
`timescale 1ns/100ps
// Contract
// - Copy-back: read setup, four source address cycles
// - Target command only after ready returns high
// - Target top address bit equals source's
// - Confirm command starts copy-back programming
// - Reissue read command after status polling; the status operation ends without issuing one
// - 90h plus address 00h enters identification
// - Wait 10us after power-up before commands
// - Hold write-protect low during power transitions
// - Second copy-back command code is 8Ah
module nsic_ctrl
#(
  parameter int POWERUP_CYC = nsic_pkg::POWERUP_CYC
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire nsic_pkg::nsic_req_type req,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  output logic [31:0]                 result,
  output logic                        result_valid,
  output logic                        top_bit_err,
  input  wire logic                   ready_busy_in,
  input  wire logic [7:0]             dq_in,
  output nsic_pkg::nsic_pins_type     pins
);
  typedef enum logic [3:0]
  {
    NSIC_PWR, NSIC_IDLE, NSIC_CMD, NSIC_ADDR, NSIC_WAITRB0, NSIC_WAITRB,
    NSIC_GAP, NSIC_READ, NSIC_DONE
  } nsic_st_type;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       rb_meta;
  logic       rb_sync;
  logic [7:0] dq_meta;
  logic [7:0] dq_sync;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end
    else
    begin
      rb_meta <= ready_busy_in;
      rb_sync <= rb_meta;
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  nsic_st_type          st;
  nsic_st_type          next_st;
  nsic_pkg::nsic_req_type cur;
  nsic_pkg::nsic_req_type next_cur;
  logic [1:0]           phase;
  logic [1:0]           next_phase;
  logic [2:0]           idx;
  logic [2:0]           next_idx;
  logic [15:0]          tmr;
  logic [15:0]          next_tmr;
  logic [31:0]          next_result;
  logic                 next_result_valid;
  logic                 next_req_ready;
  logic                 next_top_bit_err;
  logic                 cyc_start;
  logic [1:0]           cyc_kind;
  logic [7:0]           cyc_wdata;
  logic                 cyc_done;
  logic [7:0]           cyc_rdata;
  logic [31:0]          addr_sel;

  always_comb
  begin
    addr_sel = (phase == 2'h0) ? cur.src_addr : cur.dst_addr;
  end

  always_comb
  begin
    next_st           = st;
    next_cur          = cur;
    next_phase        = phase;
    next_idx          = idx;
    next_tmr          = tmr;
    next_result       = result;
    next_result_valid = 1'b0;
    next_req_ready    = 1'b0;
    next_top_bit_err  = top_bit_err;
    cyc_start         = 1'b0;
    cyc_kind          = 2'h0;
    cyc_wdata         = 8'h00;
    case (st)
      NSIC_PWR:
      begin
        if (tmr == 16'(POWERUP_CYC))
        begin
          next_st        = NSIC_IDLE;
          next_req_ready = 1'b1;
        end
        else
          next_tmr = tmr + 16'h1;
      end
      NSIC_IDLE:
      begin
        next_req_ready = 1'b1;
        if (req_valid && req.op != nsic_pkg::NSIC_OP_NONE)
        begin
          next_cur       = req;
          next_phase     = 2'h0;
          next_idx       = 3'h0;
          next_req_ready = 1'b0;
          next_result    = 32'h0;
          next_st        = NSIC_CMD;
          // Refused copy-back is flagged rather than issued
          if (req.op == nsic_pkg::NSIC_OP_COPYBACK)
          begin
            next_top_bit_err = req.src_addr[nsic_pkg::TOP_BIT_POS]
                             != req.dst_addr[nsic_pkg::TOP_BIT_POS];
            if (next_top_bit_err)
            begin
              next_st           = NSIC_IDLE;
              next_req_ready    = 1'b1;
              next_result_valid = 1'b1;
            end
          end
        end
      end
      NSIC_CMD:
      begin
        cyc_start = 1'b1;
        cyc_kind  = 2'h0;
        case (cur.op)
          nsic_pkg::NSIC_OP_COPYBACK:
            cyc_wdata = (phase == 2'h0) ? nsic_pkg::CMD_READ_MAIN :
                        (phase == 2'h1) ? nsic_pkg::CMD_COPY_DEST :
                        nsic_pkg::CMD_CONFIRM;
          nsic_pkg::NSIC_OP_STATUS:  cyc_wdata = nsic_pkg::CMD_STATUS;
          nsic_pkg::NSIC_OP_READ_ID: cyc_wdata = nsic_pkg::CMD_READ_ID;
          default:                   cyc_wdata = nsic_pkg::CMD_RESET;
        endcase
        next_st = NSIC_GAP;
      end
      NSIC_GAP:
      begin
        // Wait for the cycle engine, then route by operation
        if (cyc_done)
        begin
          next_idx = 3'h0;
          next_tmr = 16'h0;
          case (cur.op)
            nsic_pkg::NSIC_OP_COPYBACK:
              next_st = (phase == 2'h3) ? NSIC_WAITRB0 : NSIC_ADDR;
            nsic_pkg::NSIC_OP_READ_ID: next_st = NSIC_ADDR;
            nsic_pkg::NSIC_OP_STATUS:  next_st = NSIC_READ;
            default:                   next_st = NSIC_WAITRB0;
          endcase
        end
      end
      NSIC_ADDR:
      begin
        if (idx[0] == 1'b0)
        begin
          cyc_start = 1'b1;
          cyc_kind  = 2'h1;
          cyc_wdata = (cur.op == nsic_pkg::NSIC_OP_READ_ID) ? nsic_pkg::ID_ADDR
                    : addr_sel[8*idx[2:1] +: 8];
          next_idx  = idx + 3'h1;
        end
        else if (cyc_done)
        begin
          if (cur.op == nsic_pkg::NSIC_OP_READ_ID)
          begin
            next_st  = NSIC_READ;
            next_idx = 3'h0;
            next_tmr = 16'h0;
          end
          else if (idx[2:1] == 2'(nsic_pkg::ADDR_CYCLES - 1))
          begin
            next_phase = phase + 2'h1;
            next_tmr   = 16'h0;
            next_st    = NSIC_WAITRB0;
          end
          else
            next_idx = idx + 3'h1;
        end
      end
      NSIC_WAITRB0:
      begin
        // Busy may take up to tWB to appear
        next_tmr = tmr + 16'h1;
        if (tmr == 16'(nsic_pkg::TWHR_CYC + 4))
          next_st = NSIC_WAITRB;
      end
      NSIC_WAITRB:
      begin
        if (rb_sync)
        begin
          if (cur.op == nsic_pkg::NSIC_OP_COPYBACK && phase == 2'h1)
            next_st = NSIC_CMD;
          else if (cur.op == nsic_pkg::NSIC_OP_COPYBACK && phase == 2'h2)
          begin
            next_phase = 2'h3;
            next_st    = NSIC_CMD;
          end
          else
            next_st = NSIC_DONE;
        end
      end
      NSIC_READ:
      begin
        if (tmr != 16'(nsic_pkg::TWHR_CYC))
          next_tmr = tmr + 16'h1;
        else if (idx[0] == 1'b0)
        begin
          cyc_start = 1'b1;
          cyc_kind  = 2'h2;
          next_idx  = idx + 3'h1;
        end
        else if (cyc_done)
        begin
          next_result = {result[23:0], cyc_rdata};
          if (cur.op == nsic_pkg::NSIC_OP_STATUS
              || idx[2:1] == 2'(nsic_pkg::ID_BYTES - 1))
            next_st = NSIC_DONE;
          else
            next_idx = idx + 3'h1;
        end
      end
      default:
      begin
        next_result_valid = 1'b1;
        next_req_ready    = 1'b1;
        next_st           = NSIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st           <= NSIC_PWR;
      cur          <= '0;
      phase        <= 2'h0;
      idx          <= 3'h0;
      tmr          <= 16'h0;
      result       <= 32'h0;
      result_valid <= 1'b0;
      req_ready    <= 1'b0;
      top_bit_err  <= 1'b0;
    end
    else
    begin
      st           <= next_st;
      cur          <= next_cur;
      phase        <= next_phase;
      idx          <= next_idx;
      tmr          <= next_tmr;
      result       <= next_result;
      result_valid <= next_result_valid;
      req_ready    <= next_req_ready;
      top_bit_err  <= next_top_bit_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic ce_b;
  logic wp_b;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ce_b <= 1'b1;
      wp_b <= 1'b0;
    end
    else
    begin
      ce_b <= (next_st == NSIC_IDLE) || (next_st == NSIC_PWR);
      wp_b <= (next_st != NSIC_PWR);
    end
  end

  nsic_cycle u_cycle
  (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .start         (cyc_start),
    .kind          (cyc_kind),
    .wdata         (cyc_wdata),
    .dq_sync       (dq_sync),
    .done          (cyc_done),
    .rdata         (cyc_rdata),
    .cle           (pins.cle),
    .ale           (pins.ale),
    .we_b          (pins.we_b),
    .read_strobe_b (pins.read_strobe_b),
    .dq_out        (pins.dq_out),
    .dq_oe_b       (pins.dq_oe_b)
  );

  // Separate members, so each has one continuous driver beside the cycle engine
  assign pins.ce_b = ce_b;
  assign pins.wp_b = wp_b;

  ////////////////////////////////////////////////////////////////////////////
  chk_no_cmd_early: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_PWR) |-> pins.cle == 1'b0) else $error("command during power-up");
  chk_wp_powerup: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_PWR) |-> pins.wp_b == 1'b0) else $error("wp high at power-up");
  chk_dest_after_rdy: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_WAITRB && !rb_sync) |=> st != NSIC_CMD) else $error("command while busy");
  chk_top_bit_same: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_CMD && cur.op == nsic_pkg::NSIC_OP_COPYBACK)
    |-> cur.src_addr[nsic_pkg::TOP_BIT_POS] == cur.dst_addr[nsic_pkg::TOP_BIT_POS])
    else $error("top address bit differs");
  chk_reset_code: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_CMD && cur.op == nsic_pkg::NSIC_OP_RESET) |-> cyc_wdata == 8'hff)
    else $error("wrong reset code");
  chk_dest_code: assert property (@(posedge mclk) disable iff (!rst_b)
    (st == NSIC_CMD && cur.op == nsic_pkg::NSIC_OP_COPYBACK && phase == 2'h1)
    |-> cyc_wdata == 8'h8a) else $error("wrong copy-back code");
endmodule

// ===== verilog/nsic_pkg.sv
package nsic_pkg;
  localparam logic [7:0] CMD_READ_MAIN  = 8'h00;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_COPY_DEST  = 8'h8a;
  localparam logic [7:0] CMD_CONFIRM    = 8'h10;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam logic [7:0] ID_ADDR        = 8'h00;
  localparam int         ADDR_CYCLES    = 4;
  localparam int         ID_BYTES       = 4;
  localparam int         TOP_BIT_POS    = 24;
  localparam int         ST_READY_BIT   = 6;
  localparam int         ST_FAIL_BIT    = 0;
  localparam int         ST_WP_BIT      = 7;
  localparam int         CLK_MHZ        = 125;
  localparam int         POWERUP_US     = 10;
  localparam int         POWERUP_CYC    = POWERUP_US * CLK_MHZ;
  localparam int         STROBE_CYC     = 4;
  localparam int         TWHR_NS        = 60;
  localparam int         TWHR_CYC       = (TWHR_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0]
  {
    NSIC_OP_NONE,
    NSIC_OP_COPYBACK,
    NSIC_OP_STATUS,
    NSIC_OP_READ_ID,
    NSIC_OP_RESET
  } nsic_op_type;

  typedef struct packed
  {
    nsic_op_type op;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
  } nsic_req_type;

  typedef struct packed
  {
    logic        cle;
    logic        ale;
    logic        ce_b;
    logic        we_b;
    logic        read_strobe_b;
    logic        wp_b;
    logic [7:0]  dq_out;
    logic        dq_oe_b;
  } nsic_pins_type;
endpackage

// ===== verilog/nsic_cycle.sv
`timescale 1ns/100ps
// One bus cycle: command, address, or data read, with setup and strobe timing
module nsic_cycle
#(
  parameter int STROBE = nsic_pkg::STROBE_CYC
)
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] dq_sync,
  output logic            done,
  output logic [7:0]      rdata,
  output logic            cle,
  output logic            ale,
  output logic            we_b,
  output logic            read_strobe_b,
  output logic [7:0]      dq_out,
  output logic            dq_oe_b
);
  typedef enum logic [1:0] {NSIC_C_IDLE, NSIC_C_LOW, NSIC_C_HIGH} nsic_cst_type;
  nsic_cst_type cst;
  nsic_cst_type next_cst;
  logic [3:0]   cnt;
  logic [3:0]   next_cnt;
  logic [1:0]   knd;
  logic [1:0]   next_knd;
  logic [7:0]   next_rdata;
  logic         next_done;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_cst   = cst;
    next_cnt   = cnt;
    next_knd   = knd;
    next_rdata = rdata;
    next_done  = 1'b0;
    case (cst)
      NSIC_C_IDLE:
      begin
        if (start)
        begin
          next_cst = NSIC_C_LOW;
          next_knd = kind;
          next_cnt = 4'(STROBE);
        end
      end
      NSIC_C_LOW:
      begin
        if (cnt == 4'h1)
        begin
          next_cst = NSIC_C_HIGH;
          next_cnt = 4'(STROBE);
          // Sample late in the low phase; the synchroniser adds two cycles
          if (knd == 2'h2)
            next_rdata = dq_sync;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      default:
      begin
        if (cnt == 4'h1)
        begin
          next_cst  = NSIC_C_IDLE;
          next_done = 1'b1;
        end
        else
          next_cnt = cnt - 4'h1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cst   <= NSIC_C_IDLE;
      cnt   <= 4'h0;
      knd   <= 2'h0;
      rdata <= 8'h00;
      done  <= 1'b0;
    end
    else
    begin
      cst   <= next_cst;
      cnt   <= next_cnt;
      knd   <= next_knd;
      rdata <= next_rdata;
      done  <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic next_cle;
  logic next_ale;
  logic next_we_b;
  logic next_rs_b;
  logic next_oe_b;
  always_comb
  begin
    next_cle  = (next_cst != NSIC_C_IDLE) && (next_knd == 2'h0);
    next_ale  = (next_cst != NSIC_C_IDLE) && (next_knd == 2'h1);
    next_we_b = !((next_cst == NSIC_C_LOW) && (next_knd != 2'h2));
    next_rs_b = !((next_cst == NSIC_C_LOW) && (next_knd == 2'h2));
    next_oe_b = !((next_cst != NSIC_C_IDLE) && (next_knd != 2'h2));
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_b          <= 1'b1;
      read_strobe_b <= 1'b1;
      dq_oe_b       <= 1'b1;
      dq_out        <= 8'h00;
    end
    else
    begin
      cle           <= next_cle;
      ale           <= next_ale;
      we_b          <= next_we_b;
      read_strobe_b <= next_rs_b;
      dq_oe_b       <= next_oe_b;
      dq_out        <= (start && cst == NSIC_C_IDLE) ? wdata : dq_out;
    end
  end
endmodule

// ===== tb/nsic_dev_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural flash device seen from its pins; busy times are shortened
module nsic_dev_model
#(
  parameter int          READ_CYC = 40,
  parameter int          PROG_CYC = 60,
  parameter int          RST_CYC  = 30,
  parameter logic [31:0] ID_WORD  = 32'h5a3c_1e0f  // Arbitrary identity bytes
)
(
  input  wire logic                    mclk,
  input  wire nsic_pkg::nsic_pins_type pins,
  output logic [7:0]                   dq,
  output logic                         rb_pull,
  output int                           cmd_cnt,
  output int                           prog_cnt,
  output int                           proto_err
);
  logic [7:0] cmd     = 8'h00;
  logic [7:0] last    = 8'h00;
  logic [7:0] status;
  logic [7:0] val;
  logic [1:0] mode    = 2'h0;
  logic       wep     = 1'b1;
  logic       rep     = 1'b1;
  logic       in_rst  = 1'b0;
  logic       fail    = 1'b0;
  logic       src_top = 1'b0;
  logic       dst_top = 1'b0;
  logic       drive;
  int         busy    = 0;
  int         acnt    = 0;
  int         idx     = 0;

  initial
  begin
    cmd_cnt   = 0;
    prog_cnt  = 0;
    proto_err = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign status  = {pins.wp_b, busy == 0, 5'h00, fail};
  assign rb_pull = busy != 0;
  assign drive   = !pins.ce_b && !pins.read_strobe_b && !pins.cle && !pins.ale && mode != 2'h0;
  assign val     = mode == 2'h1 ? status : ID_WORD[31 - 8 * idx -: 8];
  // Released bus shows the inverse of the last byte so stale data cannot pass
  assign dq      = drive ? val : ~last;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    wep <= pins.we_b;
    rep <= pins.read_strobe_b;
    if (drive)
      last <= val;
    if (busy > 0)
      busy <= busy - 1;
    if (pins.read_strobe_b && !rep && mode == 2'h2 && idx < 3)
      idx <= idx + 1;
    if (pins.we_b && !wep && !pins.ce_b && pins.cle)
    begin
      cmd_cnt <= cmd_cnt + 1;
      if (pins.dq_out == 8'hff)
      begin
        // A reset while resetting is dropped; an aborted page keeps no defined data
        if (!(in_rst && busy > 0))
        begin
          busy   <= RST_CYC;
          in_rst <= 1'b1;
          mode   <= 2'h0;
          fail   <= 1'b0;
        end
      end
      else if (pins.dq_out == 8'h70)
        mode <= 2'h1;
      else if (busy > 0)
        proto_err <= proto_err + 1;
      else
      begin
        mode <= pins.dq_out == 8'h90 ? 2'h3 : 2'h0;
        cmd  <= pins.dq_out;
        acnt <= 0;
        if (pins.dq_out == 8'h8a && (cmd != 8'h00 || acnt != 4))
          proto_err <= proto_err + 1;
        if (pins.dq_out == 8'h10 && cmd == 8'h8a && acnt == 4)
        begin
          busy     <= PROG_CYC;
          in_rst   <= 1'b0;
          fail     <= src_top != dst_top;
          prog_cnt <= prog_cnt + 1;
        end
      end
    end
    if (pins.we_b && !wep && !pins.ce_b && pins.ale)
    begin
      if (mode == 2'h3 && pins.dq_out == 8'h00)
      begin
        mode <= 2'h2;
        idx  <= 0;
      end
      acnt <= acnt + 1;
      if (acnt == 3 && cmd == 8'h00)
      begin
        busy    <= READ_CYC;
        in_rst  <= 1'b0;
        src_top <= pins.dq_out[0];
      end
      if (acnt == 3 && cmd == 8'h8a)
        dst_top <= pins.dq_out[0];
    end
  end
endmodule

// ===== tb/nand_status_id_reset_ctrl_bench.sv
`timescale 1ns/100ps
module nand_status_id_reset_ctrl_bench;
  localparam int           RD_CYC = 40;
  localparam int           PG_CYC = 60;
  localparam int           RS_CYC = 30;
  localparam logic [31:0]  ID_W   = 32'h5a3c_1e0f;  // Arbitrary identity bytes
  logic                    mclk      = 1'b0;
  logic                    rst_b     = 1'b0;
  logic                    req_valid = 1'b0;
  nsic_pkg::nsic_req_type  req       = '0;
  nsic_pkg::nsic_pins_type pins;
  logic                    req_ready;
  logic                    result_valid;
  logic                    top_bit_err;
  logic                    rb_pull;
  logic                    e;
  logic [31:0]             result;
  logic [31:0]             r;
  logic [7:0]              dev_dq;
  logic [7:0]              dq_in;
  wire                     ready_busy_in;
  int                      error_cnt = 0;
  int                      checks    = 0;
  int                      cyc       = 0;
  int                      busy_seen = 0;
  int                      base;
  int                      cmd_cnt;
  int                      prog_cnt;
  int                      proto_err;

  // Pull-up on the shared busy line; the device only ever pulls it low
  assign ready_busy_in = ~rb_pull;
  assign dq_in         = pins.dq_oe_b ? dev_dq : pins.dq_out;

  nsic_ctrl #(.POWERUP_CYC(20)) nsic_ctrl_i
  (
    .mclk(mclk), .rst_b(rst_b), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .result(result), .result_valid(result_valid), .top_bit_err(top_bit_err),
    .ready_busy_in(ready_busy_in), .dq_in(dq_in), .pins(pins)
  );

  nsic_dev_model #(.READ_CYC(RD_CYC), .PROG_CYC(PG_CYC), .RST_CYC(RS_CYC), .ID_WORD(ID_W))
  nsic_dev_model_i
  (
    .mclk(mclk), .pins(pins), .dq(dev_dq), .rb_pull(rb_pull), .cmd_cnt(cmd_cnt),
    .prog_cnt(prog_cnt), .proto_err(proto_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always #4 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    if (!ready_busy_in)
      busy_seen++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until taken; answer sampled in its single valid cycle
  task automatic run(input nsic_pkg::nsic_op_type op, input logic [31:0] s, input logic [31:0] d);
    int n;
    n = 0;
    req.op       = op;
    req.src_addr = s;
    req.dst_addr = d;
    req_valid    = 1'b1;
    // Ready is judged settled, so the edge that follows is the one that takes the request
    while (req_ready !== 1'b1)
    begin
      @(posedge mclk);
      #1 n++;
    end
    @(posedge mclk);
    #1 req_valid = 1'b0;
    // A refused copy-back answers at the taking edge itself
    while (result_valid !== 1'b1 && n < 4000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 4000)
      error_cnt++;
    r = result;
    e = top_bit_err;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    repeat (12) @(posedge mclk);
    check(pins.wp_b, 0);
    #1 rst_b = 1'b1;
    repeat (10) @(posedge mclk);
    #1 check(req_ready, 0);
    check(cmd_cnt, 0);
    repeat (15) @(posedge mclk);
    #1 check(req_ready, 1);
  endtask

  task automatic t_read_id;
    run(nsic_pkg::NSIC_OP_READ_ID, 32'h0, 32'h0);
    check(r, ID_W);
  endtask

  task automatic t_status;
    run(nsic_pkg::NSIC_OP_STATUS, 32'h0, 32'h0);
    check(r[7:0], 8'hc0);
  endtask

  task automatic t_reset;
    busy_seen = 0;
    run(nsic_pkg::NSIC_OP_RESET, 32'h0, 32'h0);
    check(busy_seen, RS_CYC);
    run(nsic_pkg::NSIC_OP_STATUS, 32'h0, 32'h0);
    check(r[7:0], 8'hc0);
  endtask

  task automatic t_copyback;
    base      = prog_cnt;
    busy_seen = 0;
    run(nsic_pkg::NSIC_OP_COPYBACK, 32'h0100_2000, 32'h0100_4000);
    check(e, 0);
    check(prog_cnt, base + 1);
    check(busy_seen, RD_CYC + PG_CYC);
    run(nsic_pkg::NSIC_OP_STATUS, 32'h0, 32'h0);
    check(r[7:0], 8'hc0);
  endtask

  task automatic t_copy_bad;
    base = cmd_cnt;
    run(nsic_pkg::NSIC_OP_COPYBACK, 32'h0000_2000, 32'hff00_4000);
    check(e, 1);
    check(cmd_cnt, base);
  endtask

  initial
  begin
    t_powerup();
    t_read_id();
    t_status();
    t_reset();
    t_copyback();
    t_copy_bad();
    t_read_id();
    check(proto_err, 0);
    complete_run();
  end
endmodule
